// ==== rtl/dpre_pkg.sv ====
/*
 * Constants for the DMA guarded-region enable block: register byte
 * offsets, field positions, reset values and address widths.
 * Assumes a 32-bit classic Wishbone slave port with byte addressing.
 */
package dpre_pkg;

    // ------------------------------------------------------------
    // Register map (byte offsets)
    // ------------------------------------------------------------
    localparam logic [7:0] DPRE_OFF_CONTROL = 8'h64;
    localparam logic [7:0] DPRE_OFF_LOW_BASE = 8'h68;
    localparam logic [7:0] DPRE_OFF_LOW_LIMIT = 8'h6C;
    localparam logic [7:0] DPRE_OFF_HIGH_BASE = 8'h70;
    localparam logic [7:0] DPRE_OFF_HIGH_LIMIT = 8'h78;
    localparam logic [7:0] DPRE_OFF_REVISION = 8'h00;

    // ------------------------------------------------------------
    // Fields and reset values
    // ------------------------------------------------------------
    localparam int DPRE_ENABLE_BIT = 31;
    localparam int DPRE_STATE_BIT = 0;
    localparam int DPRE_MAJOR_LSB = 4;
    localparam logic [31:0] DPRE_RESET_WORD = 32'h0000_0000;
    localparam logic [3:0] DPRE_MAJOR_GUARDS_ALL = 4'h2;
    localparam int DPRE_ADDR_W = 8;
    localparam int DPRE_DMA_ADDR_W = 64;
    localparam int DPRE_LOW_ALIGN_BITS = 20;

    typedef enum logic [2:0]
    {
        DPRE_ST_IDLE = 3'b001,
        DPRE_ST_DRAIN = 3'b010,
        DPRE_ST_SETTLE = 3'b100
    } dpre_state_t;

endpackage : dpre_pkg

// ==== rtl/dpre_guard.sv ====
/*
 * Guarded-region enable and status control with low and high region
 * decode and the per-request block decision for inbound DMA.
 * Assumes the root complex reports how many translated requests are
 * still queued, and that requests are checked combinationally.
 */
// The register offsets and the Wishbone interface to the registers were decided locally.
`timescale 1ns/100ps

// Contract
// - Bit 31 of control register turns region checking off (0) or on (1).
// - With checking on and major version 2+, block DMA hitting a region.
// - The unit's own structure fetches skip the region check entirely.
// - Blocked requests are neither logged nor signalled as remapping faults.
// - Drain queued translated requests before reporting protection as on.
// - Read-only bit 0 shows region state once each operation completes.
// - Low base pads with zeros, low limit with ones; range is inclusive.
// - Low limit below low base means the low region blocks nothing.
module dpre_guard
    import dpre_pkg::*;
#(
    parameter int LOW_ALIGN_BITS = dpre_pkg::DPRE_LOW_ALIGN_BITS,
    parameter logic [3:0] MAJOR_VERSION = dpre_pkg::DPRE_MAJOR_GUARDS_ALL,
    parameter logic [3:0] MINOR_VERSION = 4'h0,
    parameter bit DRAIN_SUPPORTED = 1'b1,
    parameter int PEND_W = 8
)
(
    input wire logic CLK_SYS_IN,
    input wire logic RST_N_IN,
    input wire logic WB_CYC_IN,
    input wire logic WB_STB_IN,
    input wire logic WB_WE_IN,
    input wire logic [dpre_pkg::DPRE_ADDR_W-1:0] WB_ADR_IN,
    input wire logic [3:0] WB_SEL_IN,
    input wire logic [31:0] WB_DAT_IN,
    output logic [31:0] WB_DAT_OUT,
    output logic WB_ACK_OUT,
    output logic WB_ERR_OUT,
    input wire logic [dpre_pkg::DPRE_DMA_ADDR_W-1:0] DMA_ADDR_IN,
    input wire logic DMA_VALID_IN,
    input wire logic DMA_STRUCT_FETCH_IN,
    input wire logic [PEND_W-1:0] RC_PENDING_IN,
    output logic DMA_BLOCK_OUT,
    output logic FAULT_LOG_OUT,
    output logic REMAP_FAULT_OUT,
    output logic DRAIN_REQ_OUT,
    output logic GUARD_ACTIVE_OUT
);
    import dpre_pkg::*;

    // ------------------------------------------------------------
    // Registers and state
    // ------------------------------------------------------------
    logic guard_enable_ctl_reg;
    logic guard_state_flag_reg;
    logic [31:0] low_guard_base_reg;
    logic [31:0] low_guard_limit_reg;
    logic [63:0] high_guard_base_reg;
    logic [63:0] high_guard_limit_reg;
    dpre_state_t state_reg;
    logic ack_reg;
    logic err_reg;
    logic [31:0] rdata_reg;
    logic [31:0] low_keep_mask;
    logic bus_req;
    logic map_hit;
    logic wr_ctl;
    logic in_low;
    logic in_high;

    // Low bits below the alignment are not stored and read back as zero
    assign low_keep_mask = ~((32'h0000_0001 << LOW_ALIGN_BITS) - 32'h1);
    // No request is taken while ack or err is still up, so a held
    // strobe is never answered twice
    assign bus_req = WB_CYC_IN && WB_STB_IN && !ack_reg && !err_reg;

    // Lanes with a clear select keep their old byte
    function automatic logic [31:0] merge_sel(input logic [31:0] old_w,
                                              input logic [31:0] new_w,
                                              input logic [3:0] sel);
        logic [31:0] res;
        res = old_w;
        for (int i = 0; i < 4; i++)
        begin
            if (sel[i])
            begin
                res[i*8 +: 8] = new_w[i*8 +: 8];
            end
        end
        return res;
    endfunction : merge_sel

    // Register map decode; anything else is answered with err
    function automatic logic is_mapped(input logic [7:0] adr);
        logic hit;
        case (adr)
            DPRE_OFF_CONTROL, DPRE_OFF_LOW_BASE, DPRE_OFF_LOW_LIMIT,
            DPRE_OFF_HIGH_BASE, DPRE_OFF_HIGH_BASE + 8'h04,
            DPRE_OFF_HIGH_LIMIT, DPRE_OFF_HIGH_LIMIT + 8'h04,
            DPRE_OFF_REVISION: hit = 1'b1;
            default: hit = 1'b0;
        endcase
        return hit;
    endfunction : is_mapped

    assign map_hit = is_mapped(WB_ADR_IN);

    // Only the top lane holds a writable bit; the rest is reserved
    // or read-only status
    assign wr_ctl = bus_req && WB_WE_IN && WB_SEL_IN[3] &&
                    (WB_ADR_IN == DPRE_OFF_CONTROL);

    // ------------------------------------------------------------
    // Wishbone answer: one wait state, ack or err for one cycle
    // ------------------------------------------------------------
    always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN)
    begin
        if (!RST_N_IN)
        begin
            ack_reg <= 1'b0;
            err_reg <= 1'b0;
        end
        else
        begin
            ack_reg <= bus_req && map_hit;
            err_reg <= bus_req && !map_hit;
        end
    end

    always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN)
    begin
        if (!RST_N_IN)
        begin
            rdata_reg <= 32'h0000_0000;
        end
        // Captured at the taking edge so the word stands with ack
        else if (bus_req && !WB_WE_IN)
        begin
            case (WB_ADR_IN)
                DPRE_OFF_CONTROL: rdata_reg <=
                    {guard_enable_ctl_reg, 30'h0, guard_state_flag_reg};
                DPRE_OFF_LOW_BASE: rdata_reg <= low_guard_base_reg;
                DPRE_OFF_LOW_LIMIT: rdata_reg <= low_guard_limit_reg;
                DPRE_OFF_HIGH_BASE: rdata_reg <= high_guard_base_reg[31:0];
                DPRE_OFF_HIGH_BASE + 8'h04:
                    rdata_reg <= high_guard_base_reg[63:32];
                DPRE_OFF_HIGH_LIMIT: rdata_reg <= high_guard_limit_reg[31:0];
                DPRE_OFF_HIGH_LIMIT + 8'h04:
                    rdata_reg <= high_guard_limit_reg[63:32];
                DPRE_OFF_REVISION: rdata_reg <=
                    {24'h0, MAJOR_VERSION, MINOR_VERSION};
                default: rdata_reg <= 32'h0000_0000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Region bounds; software keeps them fixed while active
    // ------------------------------------------------------------
    // Nothing locks them in hardware; a rewrite takes effect at once
    always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN)
    begin
        if (!RST_N_IN)
        begin
            low_guard_base_reg <= DPRE_RESET_WORD;
            low_guard_limit_reg <= DPRE_RESET_WORD;
            high_guard_base_reg <= {2{DPRE_RESET_WORD}};
            high_guard_limit_reg <= {2{DPRE_RESET_WORD}};
        end
        else if (bus_req && WB_WE_IN)
        begin
            case (WB_ADR_IN)
                DPRE_OFF_LOW_BASE: low_guard_base_reg <= low_keep_mask &
                    merge_sel(low_guard_base_reg, WB_DAT_IN, WB_SEL_IN);
                DPRE_OFF_LOW_LIMIT: low_guard_limit_reg <= low_keep_mask &
                    merge_sel(low_guard_limit_reg, WB_DAT_IN, WB_SEL_IN);
                DPRE_OFF_HIGH_BASE: high_guard_base_reg[31:0] <=
                    merge_sel(high_guard_base_reg[31:0], WB_DAT_IN,
                              WB_SEL_IN);
                DPRE_OFF_HIGH_BASE + 8'h04: high_guard_base_reg[63:32] <=
                    merge_sel(high_guard_base_reg[63:32], WB_DAT_IN,
                              WB_SEL_IN);
                DPRE_OFF_HIGH_LIMIT: high_guard_limit_reg[31:0] <=
                    merge_sel(high_guard_limit_reg[31:0], WB_DAT_IN,
                              WB_SEL_IN);
                DPRE_OFF_HIGH_LIMIT + 8'h04: high_guard_limit_reg[63:32] <=
                    merge_sel(high_guard_limit_reg[63:32], WB_DAT_IN,
                              WB_SEL_IN);
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Enable bit and enable/disable sequencing
    // ------------------------------------------------------------
    // Enable bit from bit 31
    always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN)
    begin
        if (!RST_N_IN)
        begin
            guard_enable_ctl_reg <= DPRE_RESET_WORD[DPRE_ENABLE_BIT];
        end
        else if (wr_ctl)
        begin
            guard_enable_ctl_reg <= WB_DAT_IN[DPRE_ENABLE_BIT];
        end
    end

    // Blocking starts as soon as enable is set, before the status flips,
    // so nothing new slips in while the queue drains.
    always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN)
    begin
        if (!RST_N_IN)
        begin
            state_reg <= DPRE_ST_IDLE;
            guard_state_flag_reg <= DPRE_RESET_WORD[DPRE_STATE_BIT];
        end
        else
        begin
            case (state_reg)
                DPRE_ST_IDLE:
                begin
                    if (guard_enable_ctl_reg && !guard_state_flag_reg)
                    begin
                        state_reg <= DRAIN_SUPPORTED ? DPRE_ST_DRAIN
                                                     : DPRE_ST_SETTLE;
                    end
                    // Disable needs no drain: blocking stopped at the write
                    else if (!guard_enable_ctl_reg && guard_state_flag_reg)
                    begin
                        state_reg <= DPRE_ST_SETTLE;
                    end
                end
                DPRE_ST_DRAIN:
                begin
                    if (RC_PENDING_IN == '0)
                    begin
                        state_reg <= DPRE_ST_SETTLE;
                    end
                end
                DPRE_ST_SETTLE:
                begin
                    guard_state_flag_reg <= guard_enable_ctl_reg;
                    state_reg <= DPRE_ST_IDLE;
                end
                default: state_reg <= DPRE_ST_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Region decode and block decision
    // ------------------------------------------------------------
    // Inclusive window test; a limit below its base gives no window
    function automatic logic in_window(input logic [63:0] addr,
                                       input logic [63:0] base,
                                       input logic [63:0] limit);
        logic hit;
        hit = (limit >= base) && (addr >= base) && (addr <= limit);
        return hit;
    endfunction : in_window

    always_comb
    begin
        // Empty when limit below base
        // Low window lives below 4 GiB: its upper word is zero
        in_low = in_window(DMA_ADDR_IN, {32'h0, low_guard_base_reg},
            {32'h0, low_guard_limit_reg | ~low_keep_mask});
        in_high = in_window(DMA_ADDR_IN, high_guard_base_reg,
            high_guard_limit_reg);
    end

    // Follows enable, not status, so blocking starts at the write
    // Block on hit, major version 2 or above
    assign DMA_BLOCK_OUT = DMA_VALID_IN && !DMA_STRUCT_FETCH_IN &&
                           guard_enable_ctl_reg &&
                           (MAJOR_VERSION >= DPRE_MAJOR_GUARDS_ALL) &&
                           (in_low || in_high);
    // Guard blocks never feed fault logging
    assign FAULT_LOG_OUT = 1'b0;
    assign REMAP_FAULT_OUT = 1'b0;

    // ------------------------------------------------------------
    // Status and bus outputs
    // ------------------------------------------------------------
    assign DRAIN_REQ_OUT = (state_reg == DPRE_ST_DRAIN);
    assign GUARD_ACTIVE_OUT = guard_state_flag_reg;
    assign WB_ACK_OUT = ack_reg;
    assign WB_ERR_OUT = err_reg;
    assign WB_DAT_OUT = rdata_reg;

endmodule : dpre_guard

// ==== bench/dpre_guard_chk.sv ====
/* Assertions on the guarded-region block's ports.
   Assumes one Wishbone request at a time and a bind from below. */
`timescale 1ns/100ps
module dpre_guard_chk
    import dpre_pkg::*;
#(parameter int PEND_W = 8)
(
    input wire logic CLK_SYS_IN,
    input wire logic RST_N_IN,
    input wire logic WB_WE_IN,
    input wire logic [dpre_pkg::DPRE_ADDR_W-1:0] WB_ADR_IN,
    input wire logic [3:0] WB_SEL_IN,
    input wire logic [31:0] WB_DAT_IN,
    input wire logic [31:0] WB_DAT_OUT,
    input wire logic WB_ACK_OUT,
    input wire logic DMA_STRUCT_FETCH_IN,
    input wire logic [PEND_W-1:0] RC_PENDING_IN,
    input wire logic DMA_BLOCK_OUT,
    input wire logic FAULT_LOG_OUT,
    input wire logic REMAP_FAULT_OUT,
    input wire logic DRAIN_REQ_OUT,
    input wire logic GUARD_ACTIVE_OUT
);
    logic ctl_wr;
    logic en_reg;
    default clocking cb @(posedge CLK_SYS_IN); endclocking
    default disable iff (!RST_N_IN);
    assign ctl_wr = WB_ACK_OUT && WB_WE_IN && WB_SEL_IN[3]
        && WB_ADR_IN == DPRE_OFF_CONTROL;
    // Shadow of the enable bit, one cycle late on purpose
    always_ff @(posedge CLK_SYS_IN or negedge RST_N_IN)
        if (!RST_N_IN)
            en_reg <= 1'b0;
        else if (ctl_wr)
            en_reg <= WB_DAT_IN[31];
    a_no_fault_log:
        assert property (!FAULT_LOG_OUT) else $error("fault logged");
    a_no_remap_fault:
        assert property (!REMAP_FAULT_OUT) else $error("remap fault");
    a_fetch_bypass:
        assert property (DMA_STRUCT_FETCH_IN |-> !DMA_BLOCK_OUT)
        else $error("own fetch blocked");
    a_idle_no_block:
        assert property (!en_reg && !WB_ACK_OUT |-> !DMA_BLOCK_OUT)
        else $error("blocked while off");
    a_active_drained:
        assert property ($rose(GUARD_ACTIVE_OUT)
            |-> $past(RC_PENDING_IN) == '0)
        else $error("status before drain");
    a_drain_no_status:
        assert property (DRAIN_REQ_OUT |-> !GUARD_ACTIVE_OUT)
        else $error("status during drain");
    a_drain_holds:
        assert property (DRAIN_REQ_OUT && RC_PENDING_IN != '0
            |=> DRAIN_REQ_OUT)
        else $error("drain dropped early");
    a_enable_status:
        assert property (ctl_wr && WB_DAT_IN[31] && RC_PENDING_IN == '0
            && !GUARD_ACTIVE_OUT |-> ##[1:4] GUARD_ACTIVE_OUT)
        else $error("status late on enable");
    a_disable_status:
        assert property (ctl_wr && !WB_DAT_IN[31]
            |-> ##[1:3] !GUARD_ACTIVE_OUT)
        else $error("status late on disable");
    a_reserved_zero:
        assert property (WB_ACK_OUT && !WB_WE_IN
            && WB_ADR_IN == DPRE_OFF_CONTROL
            |-> WB_DAT_OUT[30:1] == '0) else $error("reserved bits set");
endmodule : dpre_guard_chk
bind dpre_guard dpre_guard_chk #(.PEND_W(PEND_W)) u_chk (.*);

// ==== bench/dpre_rc_model.sv ====
/* Root-complex queue of translated requests, drained on demand.
   Assumes the bench loads a count while the block is idle. */
`timescale 1ns/100ps
module dpre_rc_model
#(parameter int PEND_W = 8)
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic drain_req_in,
    input wire logic load_in,
    input wire logic [PEND_W-1:0] load_val_in,
    output logic [PEND_W-1:0] pending_out
);
    logic slow_reg;
    // Retires one request every other cycle, so drain is never instant
    always_ff @(posedge clk_in or negedge rst_n_in)
        if (!rst_n_in)
        begin
            pending_out <= '0;
            slow_reg <= 1'b0;
        end
        else if (load_in)
            pending_out <= load_val_in;
        else if (drain_req_in && pending_out != '0)
        begin
            slow_reg <= ~slow_reg;
            if (slow_reg)
                pending_out <= pending_out - 1'b1;
        end
endmodule : dpre_rc_model

// ==== bench/dpre_guard_test.sv ====
/* Self-checking bench for the guarded-region block.
   Assumes the root-complex model and the bound checker. */
`timescale 1ns/100ps
module dpre_guard_test;
    import dpre_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, we = 1'b0;
    logic valid = 1'b0, fetch = 1'b0, load = 1'b0, gerr;
    logic [3:0] sel = 4'h0, bsel = 4'hF;
    logic ack, err, blk, drain, act;
    logic [7:0] adr = 8'h00, pend, lval = 8'h00;
    logic [31:0] wdat = 32'h0, rdat, got, lf = 32'h0001_2528;
    logic [63:0] dma = 64'h0;
    logic [63:0] pts [8] = '{64'h2F_FFFF, 64'h30_0000, 64'h3F_FFFF,
        64'h40_0000, 64'hFFFF_FFFF, 64'h1_0000_0000, 64'h1_0000_FFFF,
        64'h1_0001_0000};
    int errors = 0, num_checks = 0, cycles = 0;
    always #12.5 clk = ~clk;
    dpre_guard #(.PEND_W(8)) DUT (.CLK_SYS_IN(clk), .RST_N_IN(rst_n),
        .WB_CYC_IN(cyc), .WB_STB_IN(cyc), .WB_WE_IN(we), .WB_ADR_IN(adr),
        .WB_SEL_IN(sel), .WB_DAT_IN(wdat), .WB_DAT_OUT(rdat),
        .WB_ACK_OUT(ack), .WB_ERR_OUT(err), .DMA_ADDR_IN(dma),
        .DMA_VALID_IN(valid), .DMA_STRUCT_FETCH_IN(fetch),
        .RC_PENDING_IN(pend), .DMA_BLOCK_OUT(blk), .FAULT_LOG_OUT(),
        .REMAP_FAULT_OUT(), .DRAIN_REQ_OUT(drain), .GUARD_ACTIVE_OUT(act));
    dpre_rc_model #(.PEND_W(8)) u_rc (.clk_in(clk), .rst_n_in(rst_n),
        .drain_req_in(drain), .load_in(load), .load_val_in(lval),
        .pending_out(pend));
    function automatic logic [31:0] nxt(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : nxt
    // Low limit decodes with its 20 low bits as ones
    function automatic logic f_blk(input logic [63:0] a, input logic f,
        input logic en, input logic lo_on);
        logic lo;
        logic hi;
        lo = lo_on && a >= 64'h30_0000 && a <= 64'h3F_FFFF;
        hi = a >= 64'h1_0000_0000 && a <= 64'h1_0000_FFFF;
        return en && !f && (lo || hi);
    endfunction : f_blk
    task automatic check(input string n, input logic [31:0] e,
        input logic [31:0] g);
        num_checks++;
        if (g !== e)
        begin
            errors++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask : check
    task automatic complete_run();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : complete_run
    task automatic wb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= bsel;
        @(posedge clk);
        while (!(ack | err))
            @(posedge clk);
        got = rdat;
        gerr = err;
        cyc <= 1'b0;
        we <= 1'b0;
        sel <= 4'h0;
        @(posedge clk);
    endtask : wb
    task automatic poll(input logic want);
        int n;
        n = 0;
        do
        begin
            wb(1'b0, DPRE_OFF_CONTROL, 32'h0);
            n++;
        end
        while (got[0] !== want && n < 60);
        check("status", {31'h0, want}, {31'h0, got[0]});
        check("active", {31'h0, want}, {31'h0, act});
    endtask : poll
    task automatic sweep(input logic en, input logic lo_on);
        for (int i = 0; i < 32; i++)
        begin
            lf = nxt(lf);
            dma <= pts[lf[2:0]];
            fetch <= lf[9] & lf[10];
            valid <= 1'b1;
            @(negedge clk);
            check("block", {31'h0, f_blk(dma, fetch, en, lo_on)},
                {31'h0, blk});
            @(posedge clk);
        end
        valid <= 1'b0;
        fetch <= 1'b0;
        $display("sweep done");
    endtask : sweep
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            errors++;
            complete_run();
        end
    end
    initial
    begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        wb(1'b0, DPRE_OFF_CONTROL, 32'h0);
        check("ctl_reset", 32'h0, got);
        bsel = 4'h7;
        wb(1'b1, DPRE_OFF_CONTROL, 32'h8000_0000);
        bsel = 4'hF;
        wb(1'b0, DPRE_OFF_CONTROL, 32'h0);
        check("ctl_lane", 32'h0, got);
        wb(1'b0, DPRE_OFF_REVISION, 32'h0);
        check("major", 32'h2, {28'h0, got[7:4]});
        wb(1'b0, 8'h20, 32'h0);
        check("unmapped", 32'h1, {31'h0, gerr});
        wb(1'b1, DPRE_OFF_LOW_BASE, 32'hFFFF_FFFF);
        wb(1'b0, DPRE_OFF_LOW_BASE, 32'h0);
        check("low_align", 32'hFFF0_0000, got);
        wb(1'b1, DPRE_OFF_LOW_BASE, 32'h0030_0000);
        wb(1'b1, DPRE_OFF_LOW_LIMIT, 32'h0030_0000);
        wb(1'b1, DPRE_OFF_HIGH_BASE, 32'h0);
        wb(1'b1, 8'h74, 32'h1);
        wb(1'b1, DPRE_OFF_HIGH_LIMIT, 32'h0000_FFFF);
        wb(1'b1, 8'h7C, 32'h1);
        $display("registers done");
        sweep(1'b0, 1'b1);
        load <= 1'b1;
        lval <= 8'h05;
        @(posedge clk);
        load <= 1'b0;
        wb(1'b1, DPRE_OFF_CONTROL, 32'hFFFF_FFFF);
        poll(1'b1);
        check("drained", 32'h0, {24'h0, pend});
        wb(1'b0, DPRE_OFF_CONTROL, 32'h0);
        check("ctl_on", 32'h8000_0001, got);
        sweep(1'b1, 1'b1);
        wb(1'b1, DPRE_OFF_CONTROL, 32'h0);
        poll(1'b0);
        wb(1'b1, DPRE_OFF_LOW_LIMIT, 32'h0010_0000);
        wb(1'b1, DPRE_OFF_CONTROL, 32'h8000_0000);
        poll(1'b1);
        sweep(1'b1, 1'b0);
        complete_run();
    end
endmodule : dpre_guard_test
